// ===== design/lfs_defines.svh
// Constants of the LED flash mode sequencer.
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH
`define LFS_ADDR_ENABLE 8'h00
`define LFS_ADDR_PRIV 8'h04
`define LFS_ADDR_CFG1 8'h08
`define LFS_ADDR_TORCH 8'h0C
`define LFS_ADDR_FLASH 8'h10
`define LFS_ADDR_FLAGS 8'h14
`define LFS_ADDR_PWM 8'h18
`define LFS_ADDR_TMO 8'h1C
`define LFS_ADDR_MON 8'h20
`define LFS_MODE_OFF 2'h0
`define LFS_MODE_PRIV 2'h1
`define LFS_MODE_TORCH 2'h2
`define LFS_MODE_FLASH 2'h3
`define LFS_EN_PRIV_HI 2
`define LFS_EN_EDGE 5
`define LFS_EN_MSG 6
`define LFS_PV_TERM 3
`define LFS_PV_SEL_A 4
`define LFS_PV_SEL_B 5
`define LFS_CF_HWTRIG 2
`define LFS_FL_TMO 0
`define LFS_FL_VFLASH 6
`define LFS_FL_VMON 7
`define LFS_MON_EN 0
`define LFS_MON_SHDN 1
`define LFS_MON_FEN 3
`define LFS_LVL_OFF 5'h00
`define LFS_LVL_TORCH0 5'h01
`define LFS_LVL_TORCH7 5'h08
`define LFS_LVL_FLASH0 5'h09
`define LFS_PWM_SLOTS 4'h9
`define LFS_PWM_SLOT_CYC 16'h0064
`define LFS_CLK_MHZ 50
`define LFS_RAMP_US 32
`define LFS_RAMP_CYC (`LFS_RAMP_US * `LFS_CLK_MHZ)
`define LFS_RESP_OKAY 2'h0
`define LFS_RESP_SLVERR 2'h2
`endif

// ===== design/lfs_pkg.sv
// Types shared by the LED flash mode sequencer.
package lfs_pkg;
  typedef struct packed {
    logic strobe;
    logic vin_low;
    logic vin_flash_low;
    logic vout_ready;
    logic headroom_low;
    logic vout_at_vin;
  } lfs_pins_type;
  typedef struct packed {
    logic en;
    logic [4:0] level;
  } lfs_src_type;
endpackage

// ===== design/lfs_top.sv
// LED flash mode sequencer with an AXI4-Lite register slave.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "lfs_defines.svh"
module lfs_top #(
  parameter int unsigned BLINK_CYC = 6400000,
  parameter int unsigned TMO_STEP_CYC = 5000000
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire lfs_pkg::lfs_pins_type pins_i,
  output lfs_pkg::lfs_src_type current_source_a_o,
  output lfs_pkg::lfs_src_type current_source_b_o,
  output logic precharge_o,
  output logic boost_o,
  output logic pass_o,
  output logic indicator_thermistor_pin_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins.
  lfs_pkg::lfs_pins_type meta_reg;
  lfs_pkg::lfs_pins_type sync_reg;
  logic strobe_d_reg;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      strobe_d_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_reg <= pins_i;
      sync_reg <= meta_reg;
      strobe_d_reg <= sync_reg.strobe;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic rd_take;
  logic flag_rd;
  logic [7:0] en_reg;
  logic [7:0] priv_reg;
  logic [7:0] cfg_reg;
  logic [7:0] torch_reg;
  logic [7:0] flash_reg;
  logic [7:0] flags_reg;
  logic [7:0] pwm_reg;
  logic [7:0] tmo_reg;
  logic [7:0] mon_reg;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `LFS_ADDR_MON) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic wr_hit(input logic go, input logic [7:0] a, input logic [7:0] t);
    wr_hit = go && (a == t);
  endfunction
  assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign do_write = ce_i && aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_take = ce_i && s_axi_arvalid_i && !rvalid_reg;
  assign flag_rd = rd_take && (s_axi_araddr_i == `LFS_ADDR_FLAGS);
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `LFS_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i[7:0];
        wstrb0_reg <= s_axi_wstrb_i[0];
      end
      if (do_write)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? `LFS_RESP_OKAY : `LFS_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `LFS_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (rd_take)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg <= mapped(s_axi_araddr_i) ? `LFS_RESP_OKAY : `LFS_RESP_SLVERR;
        case (s_axi_araddr_i)
          `LFS_ADDR_ENABLE: rdata_reg <= {24'h000000, en_reg};
          `LFS_ADDR_PRIV: rdata_reg <= {24'h000000, priv_reg};
          `LFS_ADDR_CFG1: rdata_reg <= {24'h000000, cfg_reg};
          `LFS_ADDR_TORCH: rdata_reg <= {24'h000000, torch_reg};
          `LFS_ADDR_FLASH: rdata_reg <= {24'h000000, flash_reg};
          `LFS_ADDR_FLAGS: rdata_reg <= {24'h000000, flags_reg};
          `LFS_ADDR_PWM: rdata_reg <= {24'h000000, pwm_reg};
          `LFS_ADDR_TMO: rdata_reg <= {24'h000000, tmo_reg};
          `LFS_ADDR_MON: rdata_reg <= {24'h000000, mon_reg};
          default: rdata_reg <= 32'h00000000;
        endcase
      end
      else if (s_axi_rready_i)
      begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers.
  logic wgo;
  assign wgo = do_write && wstrb0_reg;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      priv_reg <= 8'h00;
      cfg_reg <= 8'h00;
      torch_reg <= 8'h00;
      flash_reg <= 8'h00;
      pwm_reg <= 8'h00;
      tmo_reg <= 8'h00;
      mon_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_PRIV)) priv_reg <= wdata_reg;
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_CFG1)) cfg_reg <= wdata_reg;
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_TORCH)) torch_reg <= {2'h0, wdata_reg[5:0]};
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_FLASH)) flash_reg <= wdata_reg;
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_PWM)) pwm_reg <= {5'h00, wdata_reg[2:0]};
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_TMO)) tmo_reg <= {4'h0, wdata_reg[3:0]};
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_MON)) mon_reg <= wdata_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Flash control and timeout.
  logic flash_on_reg;
  logic by_strobe_reg;
  logic [31:0] tmo_cnt_reg;
  logic [31:0] tmo_lim;
  logic strobe_rise;
  logic hw_trig;
  logic flash_start;
  logic tmo_hit;
  logic flash_end;
  logic edge_mode;
  assign edge_mode = en_reg[`LFS_EN_EDGE];
  assign strobe_rise = sync_reg.strobe && !strobe_d_reg;
  assign hw_trig = cfg_reg[`LFS_CF_HWTRIG] && strobe_rise;
  assign flash_start = !flash_on_reg && (hw_trig || en_reg[1:0] == `LFS_MODE_FLASH);
  assign tmo_lim = 32'((64'(tmo_reg[3:0]) + 64'h1) * 64'(TMO_STEP_CYC));
  assign tmo_hit = flash_on_reg && (tmo_cnt_reg >= tmo_lim - 32'h1);
  always_comb
  begin
    flash_end = 1'b0;
    if (flash_on_reg)
    begin
      if (tmo_hit)
        flash_end = 1'b1;
      else if (!edge_mode)
        flash_end = (by_strobe_reg && !sync_reg.strobe) ||
                    (en_reg[1:0] == `LFS_MODE_OFF);
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      flash_on_reg <= 1'b0;
      by_strobe_reg <= 1'b0;
      tmo_cnt_reg <= 32'h00000000;
    end
    else if (ce_i)
    begin
      if (flash_end)
        flash_on_reg <= 1'b0;
      else if (flash_start)
      begin
        flash_on_reg <= 1'b1;
        by_strobe_reg <= hw_trig;
      end
      if (flash_start || (strobe_rise && !edge_mode))
        tmo_cnt_reg <= 32'h00000000;
      else if (flash_on_reg)
        tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
    end
  end
  // Mode field: bus write first, hardware end and trigger override it.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      en_reg <= 8'h00;
    else if (ce_i)
    begin
      if (wr_hit(wgo, awaddr_reg, `LFS_ADDR_ENABLE))
        en_reg <= wdata_reg;
      if (flash_end)
        en_reg[1:0] <= priv_reg[`LFS_PV_TERM] ? `LFS_MODE_OFF : `LFS_MODE_PRIV;
      else if (hw_trig)
        en_reg[1:0] <= `LFS_MODE_FLASH;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Fault flags and latched reduced conditions.
  logic vflash_hold_reg;
  logic vmon_force_reg;
  logic set_vflash;
  logic set_vmon;
  assign set_vflash = mon_reg[`LFS_MON_FEN] && sync_reg.vin_flash_low;
  assign set_vmon = mon_reg[`LFS_MON_EN] && sync_reg.vin_low;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      flags_reg <= 8'h00;
      vflash_hold_reg <= 1'b0;
      vmon_force_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (flag_rd)
        flags_reg <= 8'h00;
      if (tmo_hit)
        flags_reg[`LFS_FL_TMO] <= 1'b1;
      if (set_vflash)
        flags_reg[`LFS_FL_VFLASH] <= 1'b1;
      if (set_vmon)
        flags_reg[`LFS_FL_VMON] <= 1'b1;
      if (set_vflash && flash_on_reg)
        vflash_hold_reg <= 1'b1;
      else if (flag_rd)
        vflash_hold_reg <= 1'b0;
      if (set_vmon)
        vmon_force_reg <= 1'b1;
      else if (flag_rd && !sync_reg.vin_low)
        vmon_force_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Privacy PWM and blink timing.
  logic [15:0] slot_cnt_reg;
  logic [3:0] slot_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_ph_reg;
  logic [15:0] slot_len;
  logic [31:0] blink_lim;
  logic priv_on;
  assign slot_len = 16'((17'(pwm_reg[2:0]) + 17'h1) * 17'(`LFS_PWM_SLOT_CYC));
  assign blink_lim = 32'(64'(BLINK_CYC) << priv_reg[7:6]);
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      slot_cnt_reg <= 16'h0000;
      slot_reg <= 4'h0;
      blink_cnt_reg <= 32'h00000000;
      blink_ph_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      if (slot_cnt_reg >= slot_len - 16'h1)
      begin
        slot_cnt_reg <= 16'h0000;
        slot_reg <= (slot_reg >= `LFS_PWM_SLOTS) ? 4'h0 : slot_reg + 4'h1;
      end
      else
        slot_cnt_reg <= slot_cnt_reg + 16'h1;
      if (blink_cnt_reg >= blink_lim - 32'h1)
      begin
        blink_cnt_reg <= 32'h00000000;
        blink_ph_reg <= !blink_ph_reg;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end
  assign priv_on = (slot_reg <= {1'b0, priv_reg[2:0]}) &&
                   (blink_ph_reg || priv_reg[7:6] == 2'h3);
  ////////////////////////////////////////////////////////////////////////////
  // Current targets and ramp.
  logic [10:0] ramp_cnt_reg;
  logic ramp_tick;
  logic [4:0] lvl_a_reg;
  logic [4:0] lvl_b_reg;
  logic step_ok;
  logic requested;
  function automatic logic [4:0] target(input logic sel, input logic [2:0] tc,
                                        input logic [3:0] fc, input logic [7:0] en,
                                        input logic fon, input logic force_on,
                                        input logic shdn, input logic pon,
                                        input logic rdy);
    logic [4:0] t;
    t = `LFS_LVL_OFF;
    if (fon)
      t = force_on ? (shdn ? `LFS_LVL_OFF : `LFS_LVL_TORCH0 + 5'(tc))
                   : `LFS_LVL_FLASH0 + 5'(fc);
    else
      case (en[1:0])
        `LFS_MODE_TORCH: t = (force_on && shdn) ? `LFS_LVL_OFF
                             : `LFS_LVL_TORCH0 + 5'(tc);
        `LFS_MODE_PRIV: t = (sel && pon) ? (en[`LFS_EN_PRIV_HI] ? `LFS_LVL_TORCH7
                            : `LFS_LVL_TORCH0) : `LFS_LVL_OFF;
        default: t = `LFS_LVL_OFF;
      endcase
    target = rdy ? t : `LFS_LVL_OFF;
  endfunction
  function automatic logic [4:0] ramp(input logic [4:0] cur, input logic [4:0] tgt,
                                      input logic go, input logic jump);
    if (tgt <= cur || jump)
      ramp = tgt;
    else if (go)
      ramp = cur + 5'h1;
    else
      ramp = cur;
  endfunction
  assign ramp_tick = (ramp_cnt_reg == 11'(`LFS_RAMP_CYC - 1));
  assign step_ok = ramp_tick && !(vflash_hold_reg && flash_on_reg);
  logic priv_mode;
  assign priv_mode = !flash_on_reg && en_reg[1:0] == `LFS_MODE_PRIV;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ramp_cnt_reg <= 11'h000;
      lvl_a_reg <= `LFS_LVL_OFF;
      lvl_b_reg <= `LFS_LVL_OFF;
    end
    else if (ce_i)
    begin
      ramp_cnt_reg <= ramp_tick ? 11'h000 : ramp_cnt_reg + 11'h001;
      lvl_a_reg <= ramp(lvl_a_reg, target(priv_reg[`LFS_PV_SEL_A], torch_reg[2:0],
        flash_reg[3:0], en_reg, flash_on_reg, vmon_force_reg, mon_reg[`LFS_MON_SHDN],
        priv_on, sync_reg.vout_ready), step_ok, priv_mode);
      lvl_b_reg <= ramp(lvl_b_reg, target(priv_reg[`LFS_PV_SEL_B], torch_reg[5:3],
        flash_reg[7:4], en_reg, flash_on_reg, vmon_force_reg, mon_reg[`LFS_MON_SHDN],
        priv_on, sync_reg.vout_ready), step_ok, priv_mode);
    end
  end
  assign requested = flash_on_reg || en_reg[1:0] != `LFS_MODE_OFF;
  assign current_source_a_o = '{en: lvl_a_reg != `LFS_LVL_OFF, level: lvl_a_reg};
  assign current_source_b_o = '{en: lvl_b_reg != `LFS_LVL_OFF, level: lvl_b_reg};
  assign precharge_o = requested && !sync_reg.vout_ready;
  assign boost_o = requested && sync_reg.vout_at_vin && sync_reg.headroom_low;
  assign pass_o = requested && sync_reg.vout_at_vin && !sync_reg.headroom_low;
  assign indicator_thermistor_pin_o = en_reg[`LFS_EN_MSG];
  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_vflash_flag;
    ce_i && set_vflash |=> flags_reg[`LFS_FL_VFLASH];
  endproperty
  a_vflash_flag: assert property (p_vflash_flag) else $error("flash monitor flag missed");
  property p_hold_until_read;
    ce_i && vflash_hold_reg && flash_on_reg && !flag_rd |=> vflash_hold_reg
      && lvl_a_reg <= $past(lvl_a_reg);
  endproperty
  a_hold_until_read: assert property (p_hold_until_read) else $error("hold left early");
  property p_vmon_flag;
    ce_i && set_vmon |=> flags_reg[`LFS_FL_VMON];
  endproperty
  a_vmon_flag: assert property (p_vmon_flag) else $error("supply monitor flag missed");
  property p_vmon_stay;
    ce_i && vmon_force_reg && sync_reg.vin_low |=> vmon_force_reg;
  endproperty
  a_vmon_stay: assert property (p_vmon_stay) else $error("force left while supply low");
  property p_precharge_off;
    ce_i && !sync_reg.vout_ready |=> lvl_a_reg == `LFS_LVL_OFF && lvl_b_reg == `LFS_LVL_OFF;
  endproperty
  a_precharge_off: assert property (p_precharge_off) else $error("source on in precharge");
  property p_ramp_step;
    ce_i && !priv_mode ##1 lvl_a_reg > $past(lvl_a_reg) |-> $past(ramp_tick)
      && lvl_a_reg == $past(lvl_a_reg) + 5'h1;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");
  property p_edge_keep;
    ce_i && flash_on_reg && edge_mode && !tmo_hit |=> flash_on_reg;
  endproperty
  a_edge_keep: assert property (p_edge_keep) else $error("edge flash ended early");
  property p_level_end;
    ce_i && flash_on_reg && !edge_mode && by_strobe_reg && !sync_reg.strobe |=> !flash_on_reg;
  endproperty
  a_level_end: assert property (p_level_end) else $error("level flash kept on");
  property p_end_clear;
    ce_i && flash_end && priv_reg[`LFS_PV_TERM] |=> en_reg[1:0] == `LFS_MODE_OFF
      ##1 lvl_a_reg == `LFS_LVL_OFF && lvl_b_reg == `LFS_LVL_OFF;
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("flash end left source on");
  property p_timeout_end;
    ce_i && tmo_hit |=> !flash_on_reg && flags_reg[`LFS_FL_TMO];
  endproperty
  a_timeout_end: assert property (p_timeout_end) else $error("timeout not honoured");
  c_hw_flash: cover property (ce_i && hw_trig && !flash_on_reg ##1 flash_on_reg);
  c_timeout: cover property (tmo_hit);
  c_vflash_hold: cover property (vflash_hold_reg && flash_on_reg);
  c_priv_restart: cover property (flash_end && !priv_reg[`LFS_PV_TERM]);
endmodule

// ===== test/lfs_cap_model.sv
// Behavioural model of the output capacitor charging behind the sequencer.
`timescale 1ns/1ps
module lfs_cap_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic precharge_i,
  output logic vout_ready_o
);
  int cnt;
  // Charging takes fifty cycles, so the sources must really wait for it.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      cnt <= 0;
    else if (precharge_i && cnt < 50)
      cnt <= cnt + 1;
  end
  assign vout_ready_o = (cnt >= 50);
endmodule

// ===== test/test_led_flash_mode_sequencer.sv
// Self-checking bench for the LED flash mode sequencer.
`timescale 1ns/1ps
`include "lfs_defines.svh"
module test_led_flash_mode_sequencer;
  logic clk, rst, awv, wv, bry, arv, rry, strobe, vlow, vflow, hlow, vrdy, pre;
  logic awr, wr, bv, arr, rv, boost, pass, ind;
  logic [7:0] awa, ara;
  logic [1:0] br, rr, vr;
  logic [31:0] wd, rd, v, c, seed;
  logic [4:0] hi;
  lfs_pkg::lfs_pins_type pins;
  lfs_pkg::lfs_src_type sa, sb;
  int num_errors, checks, n, i, m, e;
  assign pins = '{strobe, vlow, vflow, vrdy, hlow, vrdy};
  lfs_top #(.BLINK_CYC(1000), .TMO_STEP_CYC(1600)) dut_u (
    .ref_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .pins_i(pins), .current_source_a_o(sa), .current_source_b_o(sb),
    .precharge_o(pre), .boost_o(boost), .pass_o(pass), .indicator_thermistor_pin_o(ind));
  lfs_cap_model cap_u (.ref_clk_i(clk), .rst_i(rst), .precharge_i(pre), .vout_ready_o(vrdy));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(negedge clk);
    n++;
    if (n > 30000)
    begin
      chk(0, 1, "wait limit");
      stop_test();
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wait_lvl(input logic [4:0] l);
    n = 0;
    while (sa.level !== l)
      tick();
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(da && dw))
    begin
      tick();
      ta = awv && awr;
      tw = wv && wr;
      @(posedge clk);
      if (ta)
        awv <= 0;
      if (tw)
        wv <= 0;
      da = da | ta;
      dw = dw | tw;
    end
    while (!bv)
      tick();
    chk(br, er, "bresp");
    @(posedge clk);
    bry <= 0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    n = 0;
    do tick(); while (!arr);
    @(posedge clk);
    arv <= 0;
    do tick(); while (!rv);
    v = rd;
    vr = rr;
    @(posedge clk);
    rry <= 0;
  endtask
  always @(negedge clk)
    if (!rst && pre)
      chk(sa.en | sb.en, 0, "source on in precharge");
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {awv, wv, bry, arv, rry, strobe, vlow, vflow, hlow} = 0;
    awa = 0;
    ara = 0;
    wd = 0;
    rst = 1;
    seed = 57;
    repeat (10) @(posedge clk);
    rst <= 0;
    rd_reg(`LFS_ADDR_ENABLE);
    chk(v, 0, "enable reset");
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 0, "flags reset");
    rd_reg(8'h3C);
    chk(vr, `LFS_RESP_SLVERR, "unmapped rresp");
    wr_reg(8'h3C, 8'h00, `LFS_RESP_SLVERR);
    // Torch ramp to a random code, then the boost and pass choice.
    c = rnd() % 7 + 1;
    wr_reg(`LFS_ADDR_TORCH, {2'h0, c[2:0], c[2:0]}, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_ENABLE, {6'h0, `LFS_MODE_TORCH}, `LFS_RESP_OKAY);
    @(negedge clk);
    chk(pre, 1, "precharge");
    wait_lvl(5'h01);
    n = 0;
    while (sa.level === 5'h01)
      tick();
    chk(n, `LFS_RAMP_CYC, "ramp step");
    wait_lvl(5'(c + 1));
    chk(sb, {1'b1, 5'(c + 1)}, "torch level");
    @(posedge clk);
    hlow <= 1;
    repeat (5) @(negedge clk);
    chk({boost, pass}, 2'h2, "boost");
    @(posedge clk);
    hlow <= 0;
    repeat (5) @(negedge clk);
    chk({boost, pass}, 2'h1, "pass");
    wr_reg(`LFS_ADDR_ENABLE, 8'h42, `LFS_RESP_OKAY);
    repeat (4) @(negedge clk);
    chk({ind, sa.level}, {1'b1, 5'(c + 1)}, "indicator");
    wr_reg(`LFS_ADDR_ENABLE, 8'h00, `LFS_RESP_OKAY);
    repeat (4) @(negedge clk);
    chk({ind, sa}, 7'h0, "off");
    // Privacy PWM on source A, high then low level.
    wr_reg(`LFS_ADDR_PWM, 8'h00, `LFS_RESP_OKAY);
    for (i = 0; i < 2; i++)
    begin
      c = (i == 0) ? 7 : rnd() % 8;
      wr_reg(`LFS_ADDR_PRIV, {2'h3, 3'h2, c[2:0]}, `LFS_RESP_OKAY);
      wr_reg(`LFS_ADDR_ENABLE, {5'h0, i == 0, `LFS_MODE_PRIV}, `LFS_RESP_OKAY);
      repeat (1500) @(negedge clk);
      m = 0;
      hi = 0;
      e = 0;
      repeat (1000)
      begin
        @(negedge clk);
        m += sa.en;
        e += sb.en;
        if (sa.level > hi)
          hi = sa.level;
      end
      chk(m, (c + 1) * 100, "duty");
      chk(hi, (i == 0) ? 8 : 1, "privacy level");
      chk(e, 0, "source b idle");
    end
    // The on phase of a blink is a whole number of PWM periods, so one blink period
    // always holds the same count of on cycles.
    c = rnd() % 2;
    wr_reg(`LFS_ADDR_PRIV, {c[1:0], 6'h17}, `LFS_RESP_OKAY);
    m = 2000 << c;
    repeat (m) @(negedge clk);
    e = 0;
    repeat (m)
    begin
      @(negedge clk);
      e += sa.en;
    end
    chk(e, 800 << c, "blink");
    // Edge-mode strobe flash: strobe low early must not end it.
    wr_reg(`LFS_ADDR_CFG1, 8'h04, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_FLASH, 8'h00, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_TMO, 8'h0B, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_ENABLE, 8'h20, `LFS_RESP_OKAY);
    @(posedge clk);
    strobe <= 1;
    repeat (100) @(posedge clk);
    strobe <= 0;
    wait_lvl(5'h09);
    e = 100 + n;
    chk(sb, 6'h29, "flash level");
    n = 0;
    while (sa.level === 5'h09)
      tick();
    e += n;
    chk(e >= 19195 && e <= 19215, 1, "flash length");
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 32'h01, "timeout flag");
    rd_reg(`LFS_ADDR_ENABLE);
    chk(v[1:0], `LFS_MODE_PRIV, "privacy back");
    // Level-mode strobe flash ended by strobe low.
    wr_reg(`LFS_ADDR_PRIV, 8'hD8, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_ENABLE, 8'h00, `LFS_RESP_OKAY);
    @(posedge clk);
    strobe <= 1;
    wait_lvl(5'h02);
    @(posedge clk);
    strobe <= 0;
    repeat (8) @(negedge clk);
    chk({sa, sb}, 12'h0, "off after flash");
    rd_reg(`LFS_ADDR_ENABLE);
    chk(v[1:0], `LFS_MODE_OFF, "mode cleared");
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 0, "no timeout");
    // Level mode flash started by a mode write; a strobe rise mid-pulse restarts the timeout.
    wr_reg(`LFS_ADDR_TMO, 8'h00, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_ENABLE, 8'h03, `LFS_RESP_OKAY);
    repeat (1000) @(posedge clk);
    strobe <= 1;
    repeat (700) @(posedge clk);
    rd_reg(`LFS_ADDR_ENABLE);
    chk(v[1:0], `LFS_MODE_FLASH, "timeout restarted");
    repeat (1000) @(posedge clk);
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 32'h01, "restarted timeout flag");
    @(posedge clk);
    strobe <= 0;
    // Supply monitors, disabled then enabled, and read-clear.
    @(posedge clk);
    vlow <= 1;
    vflow <= 1;
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 0, "monitors off");
    wr_reg(`LFS_ADDR_MON, 8'h09, `LFS_RESP_OKAY);
    repeat (5) @(negedge clk);
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 32'hC0, "monitor flags");
    @(posedge clk);
    vlow <= 0;
    vflow <= 0;
    repeat (5) @(posedge clk);
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 32'hC0, "flags held");
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 0, "flags cleared");
    // A flash monitor trip mid-ramp holds the level until the flags are read.
    wr_reg(`LFS_ADDR_TMO, 8'h0F, `LFS_RESP_OKAY);
    wr_reg(`LFS_ADDR_ENABLE, 8'h03, `LFS_RESP_OKAY);
    wait_lvl(5'h03);
    @(posedge clk);
    vflow <= 1;
    repeat (5) @(negedge clk);
    hi = sa.level;
    repeat (3300) @(negedge clk);
    chk(sa.level, hi, "ramp held");
    @(posedge clk);
    vflow <= 0;
    repeat (3) @(posedge clk);
    rd_reg(`LFS_ADDR_FLAGS);
    chk(v, 32'h40, "flash monitor flag");
    wait_lvl(hi + 5'h01);
    wr_reg(`LFS_ADDR_ENABLE, 8'h00, `LFS_RESP_OKAY);
    repeat (4) @(negedge clk);
    chk({sa, sb}, 12'h0, "off by write");
    stop_test();
  end
endmodule
